// ===== verilog/ctm_pkg.sv
// package for the compact timer module: register map, fields, types
package ctm_pkg;
// Overview of operation
// - separate interrupt pulses for comparator A match and comparator P match
// - a comparator match can clear the counter and change the output pin
// - external count clock advances on rising or falling edge, selectable
// - compare-match mode drives output high, low or toggles on match
// - the same output pin carries the PWM waveform in PWM mode when output action is high or toggle
// - low bytes reach software only through one shared 8-bit holding buffer
// - compare write: low byte fills buffer, high byte write copies buffer down
// - 16-bit read: high byte read captures low byte into buffer, low returns it
// - three modes: compare-match output, timer/counter, PWM output
// - core is a 16-bit up-counter on internal or external count clock
// - comparator P checks top eight counter bits, comparator A all sixteen
// - software cannot load the counter; run-enable rising edge clears it
// - counter clears on overflow or selected comparator match, raising interrupt
// - counter pair read-only; compare A pair readable and writable
// - pause bit holds counter value; clearing resumes from held value
// - clock select: sys/4, sys, high/16, high/64, sub, sub, ext rise, ext fall
// - run-enable rise clears counter and restores output level; fall holds value
// - mode field: 00 compare, 10 PWM, 11 timer, 01 undefined
// - output action on A match: none, low, high, toggle
// - clear source select: 0 comparator P match, 1 comparator A match

  // register addresses
  localparam logic [2:0] CTM_ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] CTM_ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] CTM_ADDR_CNTL  = 3'h2;
  localparam logic [2:0] CTM_ADDR_CNTH  = 3'h3;
  localparam logic [2:0] CTM_ADDR_CMPAL = 3'h4;
  localparam logic [2:0] CTM_ADDR_CMPAH = 3'h5;
  localparam logic [2:0] CTM_ADDR_CMPP  = 3'h6;

  // control register zero fields
  localparam int CTM_C0_PAUSE = 7;
  localparam int CTM_C0_CKSEL = 4;
  localparam int CTM_C0_RUN   = 3;
  localparam logic [7:0] CTM_C0_MASK  = 8'hF8;
  localparam logic [7:0] CTM_C0_RESET = 8'h00;
  localparam logic [7:0] CTM_C1_RESET = 8'h00;
  localparam logic [7:0] CTM_CMP_RESET = 8'h00;

  // control register one fields
  localparam int CTM_C1_MODE  = 6;
  localparam int CTM_C1_ACT   = 4;
  localparam int CTM_C1_INIT  = 3;
  localparam int CTM_C1_POL   = 2;
  localparam int CTM_C1_DPX   = 1;
  localparam int CTM_C1_CCLR  = 0;

  // clock prescale ratios
  localparam int CTM_DIV_SYS4  = 4;
  localparam int CTM_DIV_HI16  = 16;
  localparam int CTM_DIV_HI64  = 64;

  // clock select codes
  localparam logic [2:0] CTM_CK_SYS4  = 3'h0;
  localparam logic [2:0] CTM_CK_SYS   = 3'h1;
  localparam logic [2:0] CTM_CK_HI16  = 3'h2;
  localparam logic [2:0] CTM_CK_HI64  = 3'h3;
  localparam logic [2:0] CTM_CK_SUB0  = 3'h4;
  localparam logic [2:0] CTM_CK_SUB1  = 3'h5;
  localparam logic [2:0] CTM_CK_EXTR  = 3'h6;
  localparam logic [2:0] CTM_CK_EXTF  = 3'h7;

  // operating modes
  localparam logic [1:0] CTM_MODE_CMP = 2'h0;
  localparam logic [1:0] CTM_MODE_PWM = 2'h2;
  localparam logic [1:0] CTM_MODE_TMR = 2'h3;

  // output actions
  localparam logic [1:0] CTM_ACT_NONE = 2'h0;
  localparam logic [1:0] CTM_ACT_LOW  = 2'h1;
  localparam logic [1:0] CTM_ACT_HIGH = 2'h2;
  localparam logic [1:0] CTM_ACT_TOG  = 2'h3;

  // register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ctm_bus_s;

  // comparator events
  typedef struct packed {
    logic match_a;
    logic match_p;
    logic overflow;
  } ctm_evt_s;
endpackage : ctm_pkg

// ===== verilog/ctm_pin_sync.sv
// three-stage synchroniser with edge detection for the external count pin
`timescale 1ns/100ps
`default_nettype none
module ctm_pin_sync
  import ctm_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);
  logic [2:0] stage;
  logic       level;

  // shift chain; stage[0] feeds only stage[1]
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage <= 3'h0;
    end else if (clk_en) begin
      stage <= {stage[1:0], pin_in};
    end
  end

  // accepted level changes once second and third stages agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      level <= 1'b0;
    end else if (clk_en && (stage[1] == stage[2])) begin
      level <= stage[2];
    end
  end

  // one pulse per accepted edge
  assign rise = clk_en && (stage[1] == stage[2]) && stage[2] && !level;
  assign fall = clk_en && (stage[1] == stage[2]) && !stage[2] && level;
endmodule : ctm_pin_sync
`default_nettype wire

// ===== verilog/ctm_prescaler.sv
// count-clock tick generator from internal clock ratios
`timescale 1ns/100ps
`default_nettype none
module ctm_prescaler
  import ctm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       high_internal_clock,
  input  wire logic       sub_clock,
  output logic            tick_sys4,
  output logic            tick_hi16,
  output logic            tick_hi64
);
  logic [1:0] cnt_sys;
  logic [5:0] cnt_hi;

  // system divide by four
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_sys <= 2'h0;
    end else if (clk_en) begin
      cnt_sys <= cnt_sys + 2'h1;
    end
  end

  // high clock divide counter, advanced by the high clock enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_hi <= 6'h00;
    end else if (clk_en && high_internal_clock) begin
      cnt_hi <= cnt_hi + 6'h01;
    end
  end

  assign tick_sys4 = clk_en && (cnt_sys == 2'(CTM_DIV_SYS4 - 1));
  assign tick_hi16 = clk_en && high_internal_clock && (cnt_hi[3:0] == 4'(CTM_DIV_HI16 - 1));
  assign tick_hi64 = clk_en && high_internal_clock && (cnt_hi == 6'(CTM_DIV_HI64 - 1));
endmodule : ctm_prescaler
`default_nettype wire

// ===== verilog/ctm_timer.sv
// compact 16-bit timer: counter, comparators, output pin, byte registers
`timescale 1ns/100ps
`default_nettype none
module ctm_timer
  import ctm_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic [2:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic      [7:0] bus_rdata,
  input  wire logic       high_internal_clock,
  input  wire logic       sub_clock,
  input  wire logic       ext_count_clock_pin,
  output logic            timer_output_pin,
  output logic            irq_match_a,
  output logic            irq_match_p
);
  ctm_bus_s   bus;
  ctm_evt_s   evt;
  logic [7:0] timer_control_zero;
  logic [7:0] timer_control_one;
  logic [7:0] compare_a_high;
  logic [7:0] compare_a_low;
  logic [7:0] compare_p_value;
  logic [7:0] hold_buf;
  logic [15:0] counter;
  logic        run_q;
  logic        out_lvl;
  logic        tick;
  logic        tick_sys4;
  logic        tick_hi16;
  logic        tick_hi64;
  logic        sub_q;
  logic        ext_rise;
  logic        ext_fall;
  logic        run_rise;
  logic [15:0] compare_a_value;
  logic [15:0] next_counter;

  assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
  assign compare_a_value = {compare_a_high, compare_a_low};

  // field decodes
  wire       counter_run_enable    = timer_control_zero[CTM_C0_RUN];
  wire       count_pause           = timer_control_zero[CTM_C0_PAUSE];
  wire [2:0] count_clock_select    = timer_control_zero[CTM_C0_CKSEL +: 3];
  wire [1:0] operating_mode_select = timer_control_one[CTM_C1_MODE +: 2];
  wire [1:0] output_action_select  = timer_control_one[CTM_C1_ACT +: 2];
  wire       output_initial_level  = timer_control_one[CTM_C1_INIT];
  wire       output_polarity       = timer_control_one[CTM_C1_POL];
  wire       duty_period_swap      = timer_control_one[CTM_C1_DPX];
  wire       clear_source_select   = timer_control_one[CTM_C1_CCLR];

  ctm_prescaler u_presc (
    .sys_clk             (sys_clk),
    .sys_rst             (sys_rst),
    .clk_en              (clk_en),
    .high_internal_clock (high_internal_clock),
    .sub_clock           (sub_clock),
    .tick_sys4           (tick_sys4),
    .tick_hi16           (tick_hi16),
    .tick_hi64           (tick_hi64)
  );

  ctm_pin_sync u_ext (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .pin_in  (ext_count_clock_pin),
    .rise    (ext_rise),
    .fall    (ext_fall)
  );

  // sub clock is a same-domain enable level; count on its rising edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sub_q <= 1'b0;
    end else if (clk_en) begin
      sub_q <= sub_clock;
    end
  end

  // count clock selection
  always_comb begin
    unique case (count_clock_select)
      CTM_CK_SYS4: tick = tick_sys4;
      CTM_CK_SYS:  tick = clk_en;
      CTM_CK_HI16: tick = tick_hi16;
      CTM_CK_HI64: tick = tick_hi64;
      CTM_CK_SUB0,
      CTM_CK_SUB1: tick = clk_en && sub_clock && !sub_q;
      CTM_CK_EXTR: tick = ext_rise;
      CTM_CK_EXTF: tick = ext_fall;
    endcase
  end

  // run-enable edge detect
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_q <= 1'b0;
    end else if (clk_en) begin
      run_q <= counter_run_enable;
    end
  end
  assign run_rise = counter_run_enable && !run_q;

  // comparators on the current count
  assign evt = '{match_a:  (counter == compare_a_value),
                 match_p:  (counter[15:8] == compare_p_value),
                 overflow: (counter == 16'hFFFF)};

  // counter next value
  always_comb begin
    next_counter = counter;
    if (run_rise) begin
      next_counter = 16'h0000;
    end else if (counter_run_enable && !count_pause && tick) begin
      if (clear_source_select ? evt.match_a : evt.match_p) begin
        next_counter = 16'h0000;
      end else begin
        next_counter = counter + 16'h0001;
      end
    end
  end

  // counter register; no software load path
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      counter <= 16'h0000;
    end else if (clk_en) begin
      counter <= next_counter;
    end
  end

  // match qualified by an active count tick
  wire cnt_step = clk_en && counter_run_enable && !count_pause && tick;

  // interrupt pulses on matches and overflow
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_match_a <= 1'b0;
      irq_match_p <= 1'b0;
    end else if (clk_en) begin
      irq_match_a <= cnt_step && (evt.match_a || (clear_source_select && evt.overflow));
      irq_match_p <= cnt_step && (evt.match_p || (!clear_source_select && evt.overflow));
    end
  end

  // pwm duty/period selection
  wire [15:0] duty_val   = duty_period_swap ? {compare_p_value, 8'h00} : compare_a_value;
  wire        pwm_active = counter < duty_val;

  // compare-match output level
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_lvl <= 1'b0;
    end else if (clk_en) begin
      if (run_rise) begin
        out_lvl <= output_initial_level;
      end else if (cnt_step && evt.match_a) begin
        unique case (output_action_select)
          CTM_ACT_NONE: out_lvl <= out_lvl;
          CTM_ACT_LOW:  out_lvl <= 1'b0;
          CTM_ACT_HIGH: out_lvl <= 1'b1;
          CTM_ACT_TOG:  out_lvl <= !out_lvl;
        endcase
      end
    end
  end

  // output pin by mode, registered
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_output_pin <= 1'b0;
    end else if (clk_en) begin
      unique case (operating_mode_select)
        CTM_MODE_CMP: timer_output_pin <= out_lvl ^ output_polarity;
        CTM_MODE_PWM: begin
          unique case (output_action_select)
            CTM_ACT_NONE: timer_output_pin <= !output_initial_level ^ output_polarity;
            CTM_ACT_LOW:  timer_output_pin <= output_initial_level ^ output_polarity;
            default:      timer_output_pin <=
                            (pwm_active ~^ output_initial_level) ^ output_polarity;
          endcase
        end
        default:      timer_output_pin <= 1'b0;  // timer mode and undefined code
      endcase
    end
  end

  // control registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_control_zero <= CTM_C0_RESET;
      timer_control_one  <= CTM_C1_RESET;
    end else if (clk_en && bus.wr) begin
      if (bus.addr == CTM_ADDR_CTRL0) timer_control_zero <= bus.wdata & CTM_C0_MASK;
      if (bus.addr == CTM_ADDR_CTRL1) timer_control_one  <= bus.wdata;
    end
  end

  // compare registers; compare A low byte through the holding buffer, compare P written directly
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      compare_a_low   <= CTM_CMP_RESET;
      compare_a_high  <= CTM_CMP_RESET;
      compare_p_value <= CTM_CMP_RESET;
    end else if (clk_en && bus.wr) begin
      if (bus.addr == CTM_ADDR_CMPAH) begin
        compare_a_high <= bus.wdata;
        compare_a_low  <= hold_buf;
      end
      if (bus.addr == CTM_ADDR_CMPP) compare_p_value <= bus.wdata;
    end
  end

  // shared holding buffer: low write fills, high read captures
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_buf <= 8'h00;
    end else if (clk_en) begin
      if (bus.wr && bus.addr == CTM_ADDR_CMPAL) begin
        hold_buf <= bus.wdata;
      end else if (bus.rd && bus.addr == CTM_ADDR_CNTH) begin
        hold_buf <= counter[7:0];
      end else if (bus.rd && bus.addr == CTM_ADDR_CMPAH) begin
        hold_buf <= compare_a_low;
      end
    end
  end

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_rdata <= 8'h00;
    end else if (clk_en) begin
      bus_rdata <= 8'h00;
      if (bus.rd) begin
        unique case (bus.addr)
          CTM_ADDR_CTRL0: bus_rdata <= timer_control_zero;
          CTM_ADDR_CTRL1: bus_rdata <= timer_control_one;
          CTM_ADDR_CNTL,
          CTM_ADDR_CMPAL: bus_rdata <= hold_buf;
          CTM_ADDR_CNTH:  bus_rdata <= counter[15:8];
          CTM_ADDR_CMPAH: bus_rdata <= compare_a_high;
          CTM_ADDR_CMPP:  bus_rdata <= compare_p_value;
          default:        bus_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : ctm_timer
`default_nettype wire

// ===== verif/ctm_timer_sva.sv
// port-level assertion checker for the compact timer
`timescale 1ns/100ps
`default_nettype none
module ctm_timer_sva
  import ctm_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic       high_internal_clock,
  input wire logic       sub_clock,
  input wire logic       ext_count_clock_pin,
  input wire logic       timer_output_pin,
  input wire logic       irq_match_a,
  input wire logic       irq_match_p
);
  logic       run_q;
  logic       pau_q;
  logic [7:0] c1_q;
  logic       tmr;
  logic       cmp;
  logic       go;

  // shadow copies of the control registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_q <= 1'b0;
      pau_q <= 1'b0;
      c1_q  <= 8'h00;
    end else if (clk_en && bus_wr) begin
      if (bus_addr == CTM_ADDR_CTRL0) begin
        run_q <= bus_wdata[CTM_C0_RUN];
        pau_q <= bus_wdata[CTM_C0_PAUSE];
      end
      if (bus_addr == CTM_ADDR_CTRL1) begin
        c1_q <= bus_wdata;
      end
    end
  end

  // mode decode and run start strobe
  assign tmr = c1_q[7:6] == CTM_MODE_TMR;
  assign cmp = c1_q[7:6] == CTM_MODE_CMP;
  assign go  = clk_en && bus_wr && (bus_addr == CTM_ADDR_CTRL0) &&
               bus_wdata[CTM_C0_RUN] && !run_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_rdata_idle_zero: assert property (
    clk_en && !bus_rd |=> bus_rdata == 8'h00) else $error("stray read data");
  a_irq_a_pulse: assert property (
    clk_en && irq_match_a |=> !irq_match_a) else $error("long match pulse");
  a_stop_quiet: assert property (
    !run_q && !$past(run_q) |-> !irq_match_a && !irq_match_p)
    else $error("match while stopped");
  a_pause_quiet: assert property (
    pau_q && $past(pau_q) |-> !irq_match_a && !irq_match_p)
    else $error("match while paused");
  a_timer_pin_low: assert property (
    tmr && $past(tmr) && $past(tmr, 2) |-> !timer_output_pin)
    else $error("pin driven in timer mode");
  a_run_init_level: assert property (
    go && cmp |-> ##3 timer_output_pin == (c1_q[CTM_C1_INIT] ^ c1_q[CTM_C1_POL]))
    else $error("pin not at initial level");
  a_act_set_level: assert property (
    irq_match_a && cmp && (c1_q[5] != c1_q[4]) ##1 $stable(c1_q) [*3]
    |-> timer_output_pin == (c1_q[5] ^ c1_q[CTM_C1_POL]))
    else $error("pin not set by match");
  a_act_toggle: assert property (
    irq_match_a && cmp && c1_q[5:4] == CTM_ACT_TOG ##1 $stable(c1_q) [*3]
    |-> timer_output_pin != $past(timer_output_pin, 3))
    else $error("pin not toggled by match");

  c_match_a: cover property (irq_match_a && cmp);
  c_match_p: cover property (irq_match_p);
  c_timer: cover property (tmr && run_q);
endmodule : ctm_timer_sva
`default_nettype wire

// ===== verif/ctm_timer_test.sv
// self-checking bench for the compact timer
`timescale 1ns/100ps
`default_nettype none
module ctm_timer_test
  import ctm_pkg::*;
;
  logic        sys_clk   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        clk_en    = 1'b1;
  logic [2:0]  bus_addr  = 3'h0;
  logic [7:0]  bus_wdata = 8'h00;
  logic        bus_wr    = 1'b0;
  logic        bus_rd    = 1'b0;
  logic        sub_clock = 1'b0;
  logic        ext_pin   = 1'b0;
  logic [1:0]  ext_div   = 2'h0;
  logic [7:0]  bus_rdata;
  logic        pin;
  logic        irq_a;
  logic        irq_p;
  logic [15:0] v1;
  logic [15:0] v2;
  int          n;
  int          fail_count   = 0;
  int          total_checks = 0;
  int          dv [8] = '{CTM_DIV_SYS4, 1, CTM_DIV_HI16, CTM_DIV_HI64, 2, 2, 8, 8};

  // clock, sub clock every 2 cycles, external pin every 8 cycles
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    sub_clock <= ~sub_clock;
    ext_div   <= ext_div + 2'h1;
    if (ext_div == 2'h3) ext_pin <= ~ext_pin;
  end

  ctm_timer uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .high_internal_clock(1'b1), .sub_clock(sub_clock), .ext_count_clock_pin(ext_pin),
    .timer_output_pin(pin), .irq_match_a(irq_a), .irq_match_p(irq_p));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    @(posedge sys_clk);
    d = bus_rdata;
  endtask : rd

  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rchk

  task automatic rd16(output logic [15:0] v);
    rd(CTM_ADDR_CNTH, v[15:8]);
    rd(CTM_ADDR_CNTL, v[7:0]);
  endtask : rd16

  // cycles up to the next comparator A pulse, or P pulse when p is set
  task automatic wirq(input logic p = 1'b0);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((p ? irq_p : irq_a) !== 1'b1 && n < 3000);
  endtask : wirq

  // cycles up to the output pin showing the given level
  task automatic wpin(input logic lvl);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pin !== lvl && n < 3000);
  endtask : wpin

  task automatic per(input logic [7:0] c0, input int e);
    wr(CTM_ADDR_CTRL0, 8'h00);
    wr(CTM_ADDR_CTRL0, c0);
    wirq();
    wirq();
    chk(n[15:0], e[15:0]);
  endtask : per

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // hang guard
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(CTM_ADDR_CTRL0, CTM_C0_RESET);
    rchk(CTM_ADDR_CTRL1, CTM_C1_RESET);
    rchk(CTM_ADDR_CMPAH, CTM_CMP_RESET);
    rchk(CTM_ADDR_CMPP, CTM_CMP_RESET);
    wr(CTM_ADDR_CTRL0, 8'hFF);
    rchk(CTM_ADDR_CTRL0, CTM_C0_MASK);
    wr(CTM_ADDR_CNTH, 8'h5A);
    wr(CTM_ADDR_CNTL, 8'hA5);
    rchk(CTM_ADDR_CNTH, 8'h00);
    rchk(CTM_ADDR_CNTL, 8'h00);
    rchk(3'h7, 8'h00);
    wr(CTM_ADDR_CTRL0, 8'h00);
    wr(CTM_ADDR_CMPAL, 8'h34);
    wr(CTM_ADDR_CMPAH, 8'h12);
    wr(CTM_ADDR_CMPAL, 8'hEE);
    rchk(CTM_ADDR_CMPAH, 8'h12);
    rchk(CTM_ADDR_CMPAL, 8'h34);
    wr(CTM_ADDR_CMPP, 8'h81);
    rchk(CTM_ADDR_CMPP, 8'h81);
    wr(CTM_ADDR_CTRL1, 8'hA5);
    rchk(CTM_ADDR_CTRL1, 8'hA5);
    $display("register test done");
    // clear on comparator A at 3: four ticks a period
    wr(CTM_ADDR_CMPAL, 8'h03);
    wr(CTM_ADDR_CMPAH, 8'h00);
    wr(CTM_ADDR_CTRL1, 8'h01);
    for (int s = 0; s < 8; s++) begin
      per({1'b0, s[2:0], 4'h8}, 4 * dv[s]);
    end
    wr(CTM_ADDR_CTRL1, 8'h00);
    wr(CTM_ADDR_CMPP, 8'h01);
    per(8'h18, 257);
    wirq(1'b1);
    wirq(1'b1);
    chk(n[15:0], 16'h0101);
    $display("clock test done");
    for (int a = 0; a < 4; a++) begin
      wr(CTM_ADDR_CTRL0, 8'h00);
      wr(CTM_ADDR_CTRL1, {2'h0, a[1:0], a == 1, 3'h1});
      wr(CTM_ADDR_CTRL0, 8'h18);
      repeat (3) @(posedge sys_clk);
      chk({15'h0000, pin}, {15'h0000, a == 1});
      wirq();
      repeat (2) @(posedge sys_clk);
      chk({15'h0000, pin}, {15'h0000, a[1]});
    end
    wr(CTM_ADDR_CTRL1, 8'hC1);
    repeat (5) @(posedge sys_clk);
    chk({15'h0000, pin}, 16'h0000);
    // pwm: period from comparator P (257), active high while count below A (3)
    wr(CTM_ADDR_CTRL0, 8'h00);
    wr(CTM_ADDR_CTRL1, 8'hA8);
    wr(CTM_ADDR_CTRL0, 8'h18);
    wirq();
    wpin(1'b1);
    chk(n[15:0], 16'h00FE);
    wpin(1'b0);
    chk(n[15:0], 16'h0003);
    $display("output test done");
    wr(CTM_ADDR_CMPAL, 8'hFF);
    wr(CTM_ADDR_CMPAH, 8'hFF);
    wr(CTM_ADDR_CTRL0, 8'h00);
    wr(CTM_ADDR_CTRL1, 8'h01);
    wr(CTM_ADDR_CTRL0, 8'h18);
    wr(CTM_ADDR_CTRL0, 8'h98);
    rd16(v1);
    repeat (5) @(posedge sys_clk);
    rd16(v2);
    chk(v2, v1);
    wr(CTM_ADDR_CTRL0, 8'h18);
    rd16(v2);
    chk({15'h0000, v2 > v1}, 16'h0001);
    repeat (20) @(posedge sys_clk);
    wr(CTM_ADDR_CTRL0, 8'h10);
    rd16(v1);
    repeat (5) @(posedge sys_clk);
    rd16(v2);
    chk(v2, v1);
    wr(CTM_ADDR_CTRL0, 8'h18);
    rd16(v2);
    chk({15'h0000, v2 < v1}, 16'h0001);
    $display("pause test done");
    end_of_test();
  end
endmodule : ctm_timer_test

bind ctm_timer ctm_timer_sva chk_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .high_internal_clock(high_internal_clock), .sub_clock(sub_clock),
  .ext_count_clock_pin(ext_count_clock_pin), .timer_output_pin(timer_output_pin),
  .irq_match_a(irq_match_a), .irq_match_p(irq_match_p));
`default_nettype wire
